// File: ccr_pkg.sv
// Purpose: Constants for the converter configuration register bank
// Assumes: Byte-wide registers reached over the two-wire serial slave port
// Notes:   Offsets and reset values live here; field positions are coded in the next-state logic
//
// Contract
// - Slave clock phase field selects 0, 90, 180 or 270 degrees; resets 0.
// - Four-bit peak current limit field, 4800 mA plus 450 mA steps; resets 0xC.
// - Bit 7 disables the power-good comparator when set; resets zero.
// - Power-good threshold 2.50 V plus 0.1 V steps, clamped at code 11001.
// - Start-up current field 500 to 2000 mA; resets 0x3.
// - Undervoltage hysteresis 50 to 400 mV in 50 mV steps; resets 0x3.
// - Critical undervoltage threshold 4.60 V plus 50 mV steps; resets zero.
// - I/O regulator enable bit; zero feeds pads from core supply; resets one.
// - With the I/O regulator off, general-purpose pins are open-drain only.
// - Power-cycle pause of 0, 10, 100 or 500 ms; resets 0x2.
// - I/O voltage select 1.5, 1.8, 2.8 or 3.3 V; resets 0x3.
// - Undervoltage warning threshold 5.2 to 6.6 V in 0.2 V steps; resets 0x1.
// - Slave address is low four field bits then three zeros; resets 0xD.
// - Variant register holds mask revision high, package variant low.
// - Platform identifier register is eight bits, production written, resets zero.
// - Settings revision reads zero when unconfigured, else the revision.
// - Writes to 0x0E..0x2F ignored while locked; key 0x4A unlocks.
package ccr_pkg;
    localparam logic [7:0] CCR_OFS_LOCK = 8'h0D;
    localparam logic [7:0] CCR_OFS_CFG1 = 8'h0E;
    localparam logic [7:0] CCR_OFS_CFG2 = 8'h0F;
    localparam logic [7:0] CCR_OFS_CFG3 = 8'h10;
    localparam logic [7:0] CCR_OFS_UVCF = 8'h11;
    localparam logic [7:0] CCR_OFS_SUPC = 8'h13;
    localparam logic [7:0] CCR_OFS_ADRC = 8'h14;
    localparam logic [7:0] CCR_OFS_VARI = 8'h30;
    localparam logic [7:0] CCR_OFS_PART = 8'h31;
    localparam logic [7:0] CCR_OFS_PLAT = 8'h32;
    localparam logic [7:0] CCR_OFS_SREV = 8'h33;
    localparam logic [7:0] CCR_LOCK_LO = 8'h0E;
    localparam logic [7:0] CCR_LOCK_HI = 8'h2F;
    localparam logic [7:0] CCR_LOCK_KEY = 8'h4A;
    localparam logic [7:0] CCR_RST_CFG1 = 8'hA5;
    localparam logic [7:0] CCR_RST_CFG2 = 8'h1C;
    localparam logic [7:0] CCR_RST_CFG3 = 8'h17;
    localparam logic [7:0] CCR_RST_UVCF = 8'h60;
    localparam logic [7:0] CCR_RST_SUPC = 8'hD9;
    localparam logic [7:0] CCR_RST_ADRC = 8'hCD;
    localparam logic [7:0] CCR_RST_ZERO = 8'h00;
    localparam logic [6:0] CCR_PG_MAX = 7'h19;
    localparam logic [2:0] CCR_ADDR_LOW = 3'h0;
    localparam int CCR_CLK_HZ = 10_000_000;
    localparam int CCR_SCL_MIN_NS = 100;
    localparam int CCR_PAUSE_10_MS = 10;
    localparam int CCR_PAUSE_100_MS = 100;
    localparam int CCR_PAUSE_500_MS = 500;
    localparam int CCR_CYC_PER_MS = CCR_CLK_HZ / 1000;
    localparam logic [2:0] CCR_SYNC_N = 3'h2;
endpackage

// File: ccr_sync.sv
// Purpose: Two-flop synchroniser for a pin level
// Assumes: d_i is asynchronous to core_clk_i
// Notes:   First stage is read by the second stage only
`timescale 1ns/1ns
module ccr_sync (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rstn_i,
    // Data
    input wire logic d_i,
    output logic q_o
);
    typedef struct packed {
        logic s1;
        logic s2;
    } ccr_sync_t;
    ccr_sync_t st_r;
    ccr_sync_t st_nxt;

    // Shift chain
    always_comb begin
        st_nxt.s1 = d_i;
        st_nxt.s2 = st_r.s1;
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_r <= '{s1: 1'b1, s2: 1'b1};
        end else begin
            st_r <= st_nxt;
        end
    end
    assign q_o = st_r.s2;
endmodule

// File: ccr_top.sv
// Purpose: Converter configuration register bank with two-wire serial slave
// Assumes: Open-drain bus, clock and data sampled through two flops
// Notes:   Write: addr, reg, data...; read: addr, reg, restart, addr+R, data...
`timescale 1ns/1ns
module ccr_top #(
    parameter logic [7:0] PART_CODE = 8'h5A,     // Arbitrary value
    parameter logic [3:0] MASK_REVISION = 4'h0,  // Arbitrary value
    parameter logic [3:0] PACKAGE_VARIANT = 4'h0, // Arbitrary value
    parameter int PAUSE_CYC_PER_MS = ccr_pkg::CCR_CYC_PER_MS
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rstn_i,
    // Serial slave port
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    // Power-cycle request and pause
    input wire logic power_cycle_req_i,
    output logic reboot_pause_busy_o,
    // Converter settings
    output logic [1:0] slave_clock_phase_o,
    output logic [3:0] peak_current_limit_o,
    output logic power_good_disable_o,
    output logic [4:0] power_good_threshold_o,
    output logic [1:0] startup_current_o,
    output logic [2:0] undervoltage_hysteresis_o,
    output logic [4:0] undervoltage_critical_threshold_o,
    output logic io_regulator_enable_o,
    output logic gpio_open_drain_only_o,
    output logic [1:0] io_voltage_select_o,
    output logic [2:0] undervoltage_warning_threshold_o,
    output logic [6:0] bus_address_o
);
    import ccr_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef enum {
        CCR_IDLE, CCR_ADDR, CCR_AACK, CCR_RXB, CCR_RACK, CCR_TXB, CCR_TACK
    } ccr_fsm_t;

    typedef struct packed {
        ccr_fsm_t fsm;
        logic scl_q;
        logic sda_q;
        logic [7:0] shf;
        logic [3:0] bitn;
        logic rd;
        logic have_ptr;
        logic [7:0] ptr;
        logic sda_low;
        logic unlocked;
        logic [7:0] cfg1;
        logic [7:0] cfg2;
        logic [7:0] cfg3;
        logic [7:0] uvcf;
        logic [7:0] supc;
        logic [7:0] adrc;
        logic [7:0] vari;
        logic [7:0] plat;
        logic [7:0] srev;
        logic [31:0] pause_cnt;
        logic pause_busy;
        logic cyc_q;
        logic [1:0] phase;
        logic [3:0] ilim;
        logic pg_dis;
        logic [4:0] pg_thr;
        logic [1:0] stup;
        logic [2:0] uv_hys;
        logic [4:0] uv_crit;
        logic io_en;
        logic od_only;
        logic [1:0] io_sel;
        logic [2:0] uv_warn;
        logic [6:0] bus_addr;
    } ccr_state_t;

    ccr_state_t st_r;
    ccr_state_t st_nxt;
    logic scl_s;
    logic sda_s;
    logic cyc_s;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    ccr_sync u_scl (
        .core_clk_i(core_clk_i),
        .rstn_i(rstn_i),
        .d_i(scl_i),
        .q_o(scl_s)
    );
    ccr_sync u_sda (
        .core_clk_i(core_clk_i),
        .rstn_i(rstn_i),
        .d_i(sda_i),
        .q_o(sda_s)
    );
    ccr_sync u_cyc (
        .core_clk_i(core_clk_i),
        .rstn_i(rstn_i),
        .d_i(power_cycle_req_i),
        .q_o(cyc_s)
    );

    // Register read mux; unmapped offsets read zero
    function automatic logic [7:0] rd_mux(input ccr_state_t s);
        logic [7:0] v;
        v = CCR_RST_ZERO;
        case (s.ptr)
            CCR_OFS_LOCK: v = s.unlocked ? CCR_LOCK_KEY : CCR_RST_ZERO;
            CCR_OFS_CFG1: v = s.cfg1;
            CCR_OFS_CFG2: v = s.cfg2;
            CCR_OFS_CFG3: v = s.cfg3;
            CCR_OFS_UVCF: v = s.uvcf;
            CCR_OFS_SUPC: v = s.supc;
            CCR_OFS_ADRC: v = s.adrc;
            CCR_OFS_VARI: v = s.vari;
            CCR_OFS_PART: v = PART_CODE;
            CCR_OFS_PLAT: v = s.plat;
            CCR_OFS_SREV: v = s.srev;
            default: v = CCR_RST_ZERO;
        endcase
        return v;
    endfunction

    // Pause length in cycles for the selected code
    function automatic logic [31:0] pause_len(input logic [1:0] code);
        logic [31:0] n;
        case (code)
            2'h1: n = 32'(CCR_PAUSE_10_MS * PAUSE_CYC_PER_MS);
            2'h2: n = 32'(CCR_PAUSE_100_MS * PAUSE_CYC_PER_MS);
            2'h3: n = 32'(CCR_PAUSE_500_MS * PAUSE_CYC_PER_MS);
            default: n = 32'h0000_0000;
        endcase
        return n;
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic rise;
        logic fall;
        logic start;
        logic stop;
        logic wr_ok;
        logic [7:0] byte_in;
        logic [7:0] rd_byte;
        st_nxt = st_r;
        st_nxt.scl_q = scl_s;
        st_nxt.sda_q = sda_s;
        st_nxt.cyc_q = cyc_s;
        rise = scl_s && !st_r.scl_q;
        fall = !scl_s && st_r.scl_q;
        start = scl_s && st_r.scl_q && st_r.sda_q && !sda_s;
        stop = scl_s && st_r.scl_q && !st_r.sda_q && sda_s;
        byte_in = {st_r.shf[6:0], sda_s};
        rd_byte = rd_mux(st_r);
        // Lock window covers offsets 0x0E..0x2F
        wr_ok = st_r.unlocked || (st_r.ptr < CCR_LOCK_LO) || (st_r.ptr > CCR_LOCK_HI);

        if (start) begin
            st_nxt.fsm = CCR_ADDR;
            st_nxt.bitn = 4'h0;
            st_nxt.sda_low = 1'b0;
        end else if (stop) begin
            st_nxt.fsm = CCR_IDLE;
            st_nxt.sda_low = 1'b0;
        end else begin
            case (st_r.fsm)
                CCR_IDLE: begin
                    st_nxt.sda_low = 1'b0;
                end
                CCR_ADDR: begin
                    if (rise) begin
                        st_nxt.shf = byte_in;
                        st_nxt.bitn = st_r.bitn + 4'h1;
                    end else if (fall && st_r.bitn == 4'h8) begin
                        // Answer only at the configured address
                        if (st_r.shf[7:1] == st_r.bus_addr) begin
                            st_nxt.fsm = CCR_AACK;
                            st_nxt.rd = st_r.shf[0];
                            st_nxt.sda_low = 1'b1;
                            st_nxt.have_ptr = 1'b0;
                        end else begin
                            st_nxt.fsm = CCR_IDLE;
                        end
                    end
                end
                CCR_AACK: begin
                    if (fall) begin
                        st_nxt.bitn = 4'h0;
                        if (st_r.rd) begin
                            st_nxt.fsm = CCR_TXB;
                            st_nxt.shf = rd_byte;
                            st_nxt.sda_low = !rd_byte[7];
                        end else begin
                            st_nxt.fsm = CCR_RXB;
                            st_nxt.sda_low = 1'b0;
                        end
                    end
                end
                CCR_RXB: begin
                    if (rise) begin
                        st_nxt.shf = byte_in;
                        st_nxt.bitn = st_r.bitn + 4'h1;
                    end else if (fall && st_r.bitn == 4'h8) begin
                        st_nxt.fsm = CCR_RACK;
                        st_nxt.sda_low = 1'b1;
                        if (!st_r.have_ptr) begin
                            st_nxt.ptr = st_r.shf;
                            st_nxt.have_ptr = 1'b1;
                        end else begin
                            st_nxt.ptr = st_r.ptr + 8'h01;
                            if (st_r.ptr == CCR_OFS_LOCK) begin
                                // Key unlocks, anything else locks
                                st_nxt.unlocked = (st_r.shf == CCR_LOCK_KEY);
                            end else if (wr_ok) begin
                                case (st_r.ptr)
                                    CCR_OFS_CFG1: st_nxt.cfg1 = st_r.shf;
                                    CCR_OFS_CFG2: st_nxt.cfg2 = st_r.shf;
                                    CCR_OFS_CFG3: st_nxt.cfg3 = st_r.shf;
                                    CCR_OFS_UVCF: st_nxt.uvcf = st_r.shf;
                                    CCR_OFS_SUPC: st_nxt.supc = st_r.shf;
                                    CCR_OFS_ADRC: st_nxt.adrc = st_r.shf;
                                    CCR_OFS_VARI: st_nxt.vari = st_r.shf;
                                    CCR_OFS_PLAT: st_nxt.plat = st_r.shf;
                                    CCR_OFS_SREV: st_nxt.srev = st_r.shf;
                                    default: st_nxt.plat = st_r.plat;
                                endcase
                            end
                        end
                    end
                end
                CCR_RACK: begin
                    if (fall) begin
                        st_nxt.fsm = CCR_RXB;
                        st_nxt.bitn = 4'h0;
                        st_nxt.sda_low = 1'b0;
                    end
                end
                CCR_TXB: begin
                    if (rise) begin
                        st_nxt.bitn = st_r.bitn + 4'h1;
                    end else if (fall) begin
                        if (st_r.bitn == 4'h8) begin
                            st_nxt.fsm = CCR_TACK;
                            st_nxt.sda_low = 1'b0;
                            st_nxt.ptr = st_r.ptr + 8'h01;
                        end else begin
                            st_nxt.shf = {st_r.shf[6:0], 1'b0};
                            st_nxt.sda_low = !st_r.shf[6];
                        end
                    end
                end
                CCR_TACK: begin
                    // Master ACK continues, NACK ends the read
                    if (rise) begin
                        st_nxt.rd = !sda_s;
                    end else if (fall) begin
                        st_nxt.bitn = 4'h0;
                        if (st_r.rd) begin
                            st_nxt.fsm = CCR_TXB;
                            st_nxt.shf = rd_byte;
                            st_nxt.sda_low = !rd_byte[7];
                        end else begin
                            st_nxt.fsm = CCR_IDLE;
                        end
                    end
                end
                default: begin
                    st_nxt.fsm = CCR_IDLE;
                end
            endcase
        end

        // Power-cycle pause before reboot
        if (st_r.pause_busy) begin
            if (st_r.pause_cnt <= 32'h0000_0001) begin
                st_nxt.pause_busy = 1'b0;
                st_nxt.pause_cnt = 32'h0000_0000;
            end else begin
                st_nxt.pause_cnt = st_r.pause_cnt - 32'h0000_0001;
            end
        end else if (cyc_s && !st_r.cyc_q && pause_len(st_r.supc[6:5]) != 32'h0) begin
            st_nxt.pause_busy = 1'b1;
            st_nxt.pause_cnt = pause_len(st_r.supc[6:5]);
        end

        // Decoded settings registered straight to outputs
        st_nxt.phase = st_r.cfg2[7:6];
        st_nxt.ilim = st_r.cfg2[3:0];
        st_nxt.pg_dis = st_r.cfg3[7];
        // Codes above the top step clamp to it
        st_nxt.pg_thr = (st_r.cfg3[6:2] > CCR_PG_MAX[4:0]) ?
            CCR_PG_MAX[4:0] : st_r.cfg3[6:2];
        st_nxt.stup = st_r.cfg3[1:0];
        st_nxt.uv_hys = st_r.uvcf[7:5];
        st_nxt.uv_crit = st_r.uvcf[4:0];
        st_nxt.io_en = st_r.supc[7];
        st_nxt.od_only = !st_r.supc[7];
        st_nxt.io_sel = st_r.supc[4:3];
        st_nxt.uv_warn = st_r.supc[2:0];
        st_nxt.bus_addr = {st_r.adrc[3:0], CCR_ADDR_LOW};
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_r <= '0;
            st_r.fsm <= CCR_IDLE;
            st_r.scl_q <= 1'b1;
            st_r.sda_q <= 1'b1;
            // Request sync resets high; match it so no false pause follows reset
            st_r.cyc_q <= 1'b1;
            st_r.cfg1 <= CCR_RST_CFG1;
            st_r.cfg2 <= CCR_RST_CFG2;
            st_r.cfg3 <= CCR_RST_CFG3;
            st_r.uvcf <= CCR_RST_UVCF;
            st_r.supc <= CCR_RST_SUPC;
            st_r.adrc <= CCR_RST_ADRC;
            st_r.vari <= {MASK_REVISION, PACKAGE_VARIANT};
            st_r.plat <= CCR_RST_ZERO;
            st_r.srev <= CCR_RST_ZERO;
            st_r.ilim <= CCR_RST_CFG2[3:0];
            st_r.pg_thr <= CCR_RST_CFG3[6:2];
            st_r.stup <= CCR_RST_CFG3[1:0];
            st_r.uv_hys <= CCR_RST_UVCF[7:5];
            st_r.io_en <= CCR_RST_SUPC[7];
            st_r.od_only <= !CCR_RST_SUPC[7];
            st_r.io_sel <= CCR_RST_SUPC[4:3];
            st_r.uv_warn <= CCR_RST_SUPC[2:0];
            st_r.bus_addr <= {CCR_RST_ADRC[3:0], CCR_ADDR_LOW};
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Variant register is bus-writable at 0x30 even while locked; reset value seeded via params
    assign sda_o = 1'b0;
    assign sda_oe_o = st_r.sda_low;
    assign reboot_pause_busy_o = st_r.pause_busy;
    assign slave_clock_phase_o = st_r.phase;
    assign peak_current_limit_o = st_r.ilim;
    assign power_good_disable_o = st_r.pg_dis;
    assign power_good_threshold_o = st_r.pg_thr;
    assign startup_current_o = st_r.stup;
    assign undervoltage_hysteresis_o = st_r.uv_hys;
    assign undervoltage_critical_threshold_o = st_r.uv_crit;
    assign io_regulator_enable_o = st_r.io_en;
    // Pads limited to open-drain while the regulator is off
    assign gpio_open_drain_only_o = st_r.od_only;
    assign io_voltage_select_o = st_r.io_sel;
    assign undervoltage_warning_threshold_o = st_r.uv_warn;
    assign bus_address_o = st_r.bus_addr;
endmodule

// File: ccr_chk.sv
// Purpose: Port assertions for the converter configuration register bank
// Assumes: Pause length scaled by PAUSE_CYC_PER_MS
// Notes:   Bound into ccr_top after the module
`timescale 1ns/1ns
module ccr_chk #(
    parameter int PAUSE_CYC_PER_MS = 10
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rstn_i,
    // Watched ports
    input wire logic scl_i,
    input wire logic sda_o,
    input wire logic sda_oe_o,
    input wire logic power_cycle_req_i,
    input wire logic reboot_pause_busy_o,
    input wire logic [1:0] slave_clock_phase_o,
    input wire logic [3:0] peak_current_limit_o,
    input wire logic [4:0] power_good_threshold_o,
    input wire logic io_regulator_enable_o,
    input wire logic gpio_open_drain_only_o,
    input wire logic [6:0] bus_address_o
);
    localparam int P1 = 10 * PAUSE_CYC_PER_MS;
    localparam int P2 = 100 * PAUSE_CYC_PER_MS;
    localparam int P3 = 500 * PAUSE_CYC_PER_MS;
    int busy_cnt_r;
    default clocking dcb @(posedge core_clk_i);
    endclocking
    default disable iff (!rstn_i);
    // Pause length; a small tolerance absorbs the request synchroniser
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) busy_cnt_r <= 0;
        else busy_cnt_r <= reboot_pause_busy_o ? busy_cnt_r + 1 : 0;
    end
    // Reset values, limits and pin relations
    reset_vals_a: assert property ($rose(rstn_i) |-> peak_current_limit_o == 4'hC
        && slave_clock_phase_o == 2'h0 && bus_address_o == 7'h68) else $error("reset values");
    od_only_a: assert property (gpio_open_drain_only_o == !io_regulator_enable_o)
        else $error("open-drain flag not inverse of enable");
    addr_low_a: assert property (bus_address_o[2:0] == 3'h0)
        else $error("low address bits not zero");
    pg_clamp_a: assert property (power_good_threshold_o <= 5'h19)
        else $error("threshold above clamp");
    sda_low_a: assert property (!sda_o)
        else $error("data pin driven high");
    ack_edge_a: assert property ($changed(sda_oe_o) |-> !scl_i)
        else $error("data changed with clock high");
    busy_cause_a: assert property ($rose(reboot_pause_busy_o) |-> power_cycle_req_i)
        else $error("pause without request");
    busy_len_a: assert property ($fell(reboot_pause_busy_o) |-> busy_cnt_r inside
        {[P1 - 2:P1 + 2], [P2 - 2:P2 + 2], [P3 - 2:P3 + 2]}) else $error("pause length");
    cover property ($rose(sda_oe_o));
    cover property ($fell(reboot_pause_busy_o));
    cover property ($fell(io_regulator_enable_o));
endmodule
bind ccr_top ccr_chk #(.PAUSE_CYC_PER_MS(PAUSE_CYC_PER_MS)) u_chk (
    .core_clk_i(core_clk_i), .rstn_i(rstn_i), .scl_i(scl_i), .sda_o(sda_o),
    .sda_oe_o(sda_oe_o), .power_cycle_req_i(power_cycle_req_i),
    .reboot_pause_busy_o(reboot_pause_busy_o), .slave_clock_phase_o(slave_clock_phase_o),
    .peak_current_limit_o(peak_current_limit_o), .power_good_threshold_o(power_good_threshold_o),
    .io_regulator_enable_o(io_regulator_enable_o),
    .gpio_open_drain_only_o(gpio_open_drain_only_o), .bus_address_o(bus_address_o));

// File: ccr_tb_top.sv
// Purpose: Self-checking bench for the register bank over the serial port
// Assumes: Pause scaled to 10 cycles per ms; bus phases of 10 clocks
// Notes:   Data line is a wired-AND of bench and slave
`timescale 1ns/1ns
module ccr_tb_top;
    typedef logic [7:0] ccr_bq_t[$];
    logic core_clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic scl = 1'b1;
    logic tb_sda = 1'b1;
    logic req = 1'b0;
    logic sda_o, sda_oe_o, busy, pg_dis, io_en, od_only;
    logic [1:0] phase, stup, io_sel;
    logic [3:0] ilim;
    logic [4:0] pg_thr, crit;
    logic [2:0] hys, warn;
    logic [6:0] bus_adr;
    logic [6:0] adr = 7'h68;
    logic [15:0] rst_tab[11] = '{16'h0D00, 16'h0F1C, 16'h1017, 16'h1160, 16'h1200,
        16'h13D9, 16'h14CD, 16'h3027, 16'h313C, 16'h3200, 16'h3300};
    int checks = 0;
    int miscompares = 0;
    // A released line reads high; whoever pulls low wins
    wire sda_w = tb_sda & (sda_oe_o ? sda_o : 1'b1);
    always #50 core_clk_i = ~core_clk_i;
    ccr_top #(.PART_CODE(8'h3C), .MASK_REVISION(4'h2), .PACKAGE_VARIANT(4'h7), // Arbitrary
        .PAUSE_CYC_PER_MS(10)) dut (
        .core_clk_i(core_clk_i), .rstn_i(rstn_i), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o),
        .sda_oe_o(sda_oe_o), .power_cycle_req_i(req), .reboot_pause_busy_o(busy),
        .slave_clock_phase_o(phase), .peak_current_limit_o(ilim), .power_good_disable_o(pg_dis),
        .power_good_threshold_o(pg_thr), .startup_current_o(stup),
        .undervoltage_hysteresis_o(hys), .undervoltage_critical_threshold_o(crit),
        .io_regulator_enable_o(io_en), .gpio_open_drain_only_o(od_only),
        .io_voltage_select_o(io_sel), .undervoltage_warning_threshold_o(warn),
        .bus_address_o(bus_adr));
    // ----------------------------------------
    // Bus and compare tasks
    // ----------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask
    task automatic finish_test;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        checks++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic chk1(input logic g, input logic e);
        chk8({7'h00, g}, {7'h00, e});
    endtask
    // Data moves only while the clock is low, well clear of the falling edge
    task automatic bit_io(input logic b, output logic r);
        tick(3);
        tb_sda = b;
        tick(7);
        scl = 1'b1;
        tick(5);
        r = sda_w;
        tick(5);
        scl = 1'b0;
    endtask
    task automatic start_c;
        tick(3);
        tb_sda = 1'b1;
        tick(7);
        scl = 1'b1;
        tick(10);
        tb_sda = 1'b0;
        tick(10);
        scl = 1'b0;
    endtask
    task automatic stop_c;
        tick(3);
        tb_sda = 1'b0;
        tick(7);
        scl = 1'b1;
        tick(10);
        tb_sda = 1'b1;
        tick(10);
    endtask
    task automatic tx(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = !r;
    endtask
    task automatic rx(output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(1'b1, r);
    endtask
    task automatic wr(input logic [7:0] p, input ccr_bq_t d);
        logic k;
        start_c();
        tx({adr, 1'b0}, k);
        chk1(k, 1'b1);
        tx(p, k);
        foreach (d[i]) tx(d[i], k);
        stop_c();
    endtask
    task automatic rd(input logic [7:0] p, input logic [7:0] e);
        logic k;
        logic [7:0] v;
        start_c();
        tx({adr, 1'b0}, k);
        tx(p, k);
        start_c();
        tx({adr, 1'b1}, k);
        rx(v);
        stop_c();
        chk8(v, e);
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset;
        chk8({phase, pg_dis, 1'b0, ilim}, 8'h0C);
        chk8({pg_thr, stup, 1'b0}, 8'h2E);
        chk8({hys, crit}, 8'h60);
        chk8({io_en, od_only, io_sel, 1'b0, warn}, 8'hB1);
        chk8({1'b0, bus_adr}, 8'h68);
        foreach (rst_tab[i]) rd(rst_tab[i][15:8], rst_tab[i][7:0]);
    endtask
    // Locked write is acknowledged yet dropped; key opens, burst auto-increments
    task automatic t_lock;
        wr(8'h0F, '{8'h00});
        rd(8'h0F, 8'h1C);
        wr(8'h0D, '{8'h4A});
        rd(8'h0D, 8'h4A);
        wr(8'h0F, '{8'hDA, 8'hFF, 8'hE8});
        chk8({phase, pg_dis, 1'b0, ilim}, 8'hEA);
        chk8({pg_thr, stup, 1'b0}, 8'hCE);
        chk8({hys, crit}, 8'hE8);
        rd(8'h11, 8'hE8);
        wr(8'h10, '{8'hE0});
        chk8({pg_thr, stup, 1'b0}, 8'hC0);
        chk1(pg_dis, 1'b1);
        wr(8'h13, '{8'h00});
        chk8({io_en, od_only, io_sel, 1'b0, warn}, 8'h40);
        wr(8'h13, '{8'hFF});
        chk8({io_en, od_only, io_sel, 1'b0, warn}, 8'hB7);
        wr(8'h31, '{8'h00});
        rd(8'h31, 8'h3C);
        wr(8'h32, '{8'h5A});
        rd(8'h32, 8'h5A);
    endtask
    task automatic t_addr;
        logic k;
        wr(8'h14, '{8'hC5});
        chk8({1'b0, bus_adr}, 8'h28);
        start_c();
        tx(8'hD0, k);
        stop_c();
        chk1(k, 1'b0);
        adr = 7'h28;
        rd(8'h14, 8'hC5);
        wr(8'h14, '{8'hCD});
        adr = 7'h68;
        chk8({1'b0, bus_adr}, 8'h68);
    endtask
    // Every pause code; request held through the whole pause
    task automatic t_pause;
        int e, n;
        for (int c = 0; c < 4; c++) begin
            e = (c == 0) ? 0 : (c == 1) ? 100 : (c == 2) ? 1000 : 5000;
            wr(8'h13, '{{1'b1, c[1:0], 5'h19}});
            n = 0;
            req = 1'b1;
            repeat (e + 50) begin
                tick(1);
                if (busy === 1'b1) n++;
            end
            req = 1'b0;
            tick(5);
            chk1(n >= e - 2 && n <= e + 2, 1'b1);
        end
        wr(8'h0D, '{8'h00});
        rd(8'h0D, 8'h00);
        wr(8'h0F, '{8'h00});
        rd(8'h0F, 8'hDA);
    endtask
    initial begin
        repeat (6) @(posedge core_clk_i);
        #1 rstn_i = 1'b1;
        tick(3);
        t_reset();
        t_lock();
        t_addr();
        t_pause();
        finish_test();
    end
    // Watchdog well past the expected length of the run
    initial begin
        repeat (90000) @(posedge core_clk_i);
        miscompares++;
        finish_test();
    end
endmodule
